// ### exdf_unit.sv
`default_nettype none
// Summary of operation
// - rawpri -1 return clears banked HardFault active
// - rawpri -2 return clears banked NMI active
// - rawpri -3 return clears Secure HardFault active
// - nonnegative rawpri clears returning exception active
// - disable and base masks untouched on return
// - main extension, nonnegative rawpri: clear fault mask bit0
// - fault mask bank follows target domain
// - terminal higher priority derived fault becomes target
// - terminal lower fault: activate original, lockup
// - main extension, monitor fault not preempting: pend monitor
// - higher priority derived fault taken first
// - lower fault requesting lockup: lockup now
// - lower fault otherwise: take original, pend
// - main extension: escalated to HardFault sets escalated flag
// - pend derived fault unless locking up or already locked up; the monitor case pends monitor instead
// - terminal fault while taking target re-resolves
// - nonterminal faults ignored while taking target
// - terminal means entry prevented, vector fault
// - HardFault -3 or -1, NMI -2
module exdf_unit (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        RET_VALID,
   input  wire logic [9:0]  RET_RAWPRI,
   input  wire logic [8:0]  RET_EXC,
   input  wire logic        RET_TGT_SEC,
   input  wire logic        DF_VALID,
   input  wire logic [8:0]  DF_FAULT,
   input  wire logic [8:0]  DF_ORIG_FAULT,
   input  wire logic        DF_SEC,
   input  wire logic        DF_TERMINAL,
   input  wire logic        DF_LOCKUP,
   input  wire logic [9:0]  DF_PRI,
   input  wire logic [8:0]  OE_EXC,
   input  wire logic        OE_SEC,
   input  wire logic [9:0]  OE_PRI,
   input  wire logic [9:0]  PE_PRI,
   input  wire logic        ACT_VALID,
   input  wire logic [8:0]  ACT_EXC,
   input  wire logic        ACT_SEC,
   input  wire logic        DBG_LOCKUP_EXIT,
   output logic             TAKE_VALID,
   output logic      [8:0]  TAKE_EXC,
   output logic             TAKE_SEC,
   output logic             LOCKUP,
   output logic      [9:0]  LOCKUP_PRI
);
   // ************************************************************
   // configuration and state
   // ************************************************************
   logic [2:0] ctrl_q;
   logic [exdf_pkg::NBITS-1:0] active_q;
   logic [exdf_pkg::NBITS-1:0] pend_q;
   logic fm_s_q;
   logic fm_ns_q;
   logic [3:0] dismask_q;
   logic [7:0] base_priority_mask_q;
   logic escal_q;
   logic lockup_q;
   logic [9:0] lockup_pri_q;
   logic resolving_q;
   logic nstgt, mainext, secext;
   assign nstgt = ctrl_q[exdf_pkg::CTRL_NSTGT];
   assign mainext = ctrl_q[exdf_pkg::CTRL_MAINEXT];
   assign secext = ctrl_q[exdf_pkg::CTRL_SECEXT];

   // maps an exception and domain to its active/pending bit
   function automatic logic [exdf_pkg::NBITS-1:0] exc_bit(input logic [8:0] exc,
                                                          input logic sec);
      logic [exdf_pkg::NBITS-1:0] m;
      m = '0;
      if (exc == exdf_pkg::EXC_HARDFAULT) begin
         m[sec ? exdf_pkg::B_HF_S : exdf_pkg::B_HF_NS] = 1'b1;
      end else if (exc == exdf_pkg::EXC_NMI) begin
         m[sec ? exdf_pkg::B_NMI_S : exdf_pkg::B_NMI_NS] = 1'b1;
      end else if (exc == exdf_pkg::EXC_DBGMON) begin
         m[exdf_pkg::B_DBGMON] = 1'b1;
      end else if (exc != exdf_pkg::EXC_NONE) begin
         m[sec ? exdf_pkg::B_OTHER_S : exdf_pkg::B_OTHER_NS] = 1'b1;
      end
      return m;
   endfunction

   // ************************************************************
   // exception return: which active bit to clear
   // ************************************************************
   logic signed [9:0] rawpri;
   logic [exdf_pkg::NBITS-1:0] ret_clr;
   assign rawpri = RET_RAWPRI;
   always_comb begin
      ret_clr = '0;
      if (RET_VALID) begin
         if (rawpri == exdf_pkg::PRI_HF_NS) begin
            ret_clr = exc_bit(exdf_pkg::EXC_HARDFAULT, !nstgt);
         end else if (rawpri == exdf_pkg::PRI_NMI) begin
            ret_clr = exc_bit(exdf_pkg::EXC_NMI, !nstgt);
         end else if (rawpri == exdf_pkg::PRI_HF_S) begin
            ret_clr = exc_bit(exdf_pkg::EXC_HARDFAULT, 1'b1);
         end else begin
            ret_clr = exc_bit(RET_EXC, secext && RET_TGT_SEC);
         end
      end
   end

   // ************************************************************
   // derived fault resolution
   // ************************************************************
   logic signed [9:0] df_pri, oe_pri, pe_pri;
   logic df_beats_oe, df_beats_pe, df_is_mon, df_act;
   logic res_lock, res_pend_mon, res_take_oe;
   assign df_pri = DF_PRI;
   assign oe_pri = OE_PRI;
   assign pe_pri = PE_PRI;
   assign df_beats_oe = df_pri < oe_pri;
   assign df_beats_pe = df_pri < pe_pri;
   assign df_is_mon = mainext && (DF_ORIG_FAULT == exdf_pkg::EXC_DBGMON);
   // while taking a target, only terminal faults count
   assign df_act = DF_VALID && !lockup_q && (DF_TERMINAL || !resolving_q);
   always_comb begin
      res_lock = 1'b0;
      res_pend_mon = 1'b0;
      res_take_oe = 1'b0;
      if (DF_TERMINAL) begin
         res_lock = !df_beats_oe;
      end else if (df_is_mon && !df_beats_pe) begin
         res_pend_mon = 1'b1;
         res_take_oe = 1'b1;
      end else if (!df_beats_oe) begin
         res_lock = DF_LOCKUP;
         res_take_oe = !DF_LOCKUP;
      end
   end

   // target output; a later fault on it reuses target as original
   always_ff @(posedge CLK) begin
      if (RESET) begin
         TAKE_VALID <= 1'b0;
         TAKE_EXC <= exdf_pkg::EXC_NONE;
         TAKE_SEC <= 1'b0;
         resolving_q <= 1'b0;
      end else begin
         TAKE_VALID <= df_act && !res_lock;
         if (df_act && !res_lock) begin
            TAKE_EXC <= res_take_oe ? OE_EXC : DF_FAULT;
            TAKE_SEC <= res_take_oe ? OE_SEC : DF_SEC;
            resolving_q <= 1'b1;
         end else if (ACT_VALID || RET_VALID) begin
            resolving_q <= 1'b0;
         end
      end
   end

   // lockup held until reset or debug exit
   always_ff @(posedge CLK) begin
      if (RESET) begin
         lockup_q <= 1'b0;
         lockup_pri_q <= exdf_pkg::PRI_ZERO;
      end else if (df_act && res_lock) begin
         lockup_q <= 1'b1;
         lockup_pri_q <= OE_PRI;
      end else if (DBG_LOCKUP_EXIT) begin
         lockup_q <= 1'b0;
      end
   end
   assign LOCKUP = lockup_q;
   assign LOCKUP_PRI = lockup_pri_q;

   // ************************************************************
   // active and pending bits
   // ************************************************************
   logic [exdf_pkg::NBITS-1:0] act_set, pend_set;
   always_comb begin
      act_set = '0;
      pend_set = '0;
      if (ACT_VALID) begin
         act_set = exc_bit(ACT_EXC, ACT_SEC);
      end
      if (df_act && res_lock) begin
         act_set = act_set | exc_bit(OE_EXC, OE_SEC);
      end
      if (df_act && !res_lock) begin
         pend_set = exc_bit(DF_FAULT, DF_SEC);
         if (res_pend_mon) begin
            pend_set = exc_bit(exdf_pkg::EXC_DBGMON, DF_SEC);
         end
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         active_q <= '0;
      end else begin
         active_q <= (active_q & ~ret_clr) | act_set;
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pend_q <= '0;
      end else if (ACT_VALID) begin
         pend_q <= (pend_q & ~exc_bit(ACT_EXC, ACT_SEC)) | pend_set;
      end else begin
         pend_q <= pend_q | pend_set;
      end
   end

   // escalation flag: software clears by writing one, set wins
   logic esc_set;
   assign esc_set = df_act && !res_lock && mainext && DF_FAULT == exdf_pkg::EXC_HARDFAULT
                    && DF_ORIG_FAULT != exdf_pkg::EXC_HARDFAULT;
   logic wr_st;
   assign wr_st = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
                  && WB_ADR_I == exdf_pkg::ADR_STATUS;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         escal_q <= 1'b0;
      end else if (esc_set) begin
         escal_q <= 1'b1;
      end else if (wr_st && WB_DAT_I[exdf_pkg::ST_ESCAL]) begin
         escal_q <= 1'b0;
      end
   end

   // fault masks; disable and base masks are never written on return
   logic fm_clr;
   assign fm_clr = RET_VALID && mainext && rawpri >= exdf_pkg::PRI_ZERO;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         fm_s_q <= 1'b0;
         fm_ns_q <= 1'b0;
      end else if (fm_clr) begin
         if (secext && RET_TGT_SEC) begin
            fm_s_q <= 1'b0;
         end else begin
            fm_ns_q <= 1'b0;
         end
      end else if (wr_st) begin
         fm_s_q <= fm_s_q | WB_DAT_I[exdf_pkg::ST_FM_S];
         fm_ns_q <= fm_ns_q | WB_DAT_I[exdf_pkg::ST_FM_NS];
      end
   end

   // ************************************************************
   // wishbone slave, one wait-state ack
   // ************************************************************
   logic req;
   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl_q <= exdf_pkg::CTRL_RST;
         dismask_q <= '0;
         base_priority_mask_q <= '0;
      end else if (req && WB_WE_I && WB_ADR_I == exdf_pkg::ADR_CTRL && WB_SEL_I[0]) begin
         ctrl_q <= WB_DAT_I[2:0];
      end else if (wr_st) begin
         dismask_q <= WB_DAT_I[exdf_pkg::ST_DISMASK +: 4];
         if (WB_SEL_I[1]) begin
            base_priority_mask_q <= WB_DAT_I[exdf_pkg::ST_BASE_PRIORITY_MASK +: 8];
         end
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         WB_ACK_O <= req;
         WB_DAT_O <= '0;
         if (req && !WB_WE_I) begin
            case (WB_ADR_I)
               exdf_pkg::ADR_CTRL: WB_DAT_O <= {29'h0, ctrl_q};
               exdf_pkg::ADR_STATUS: WB_DAT_O <= {16'h0, base_priority_mask_q, dismask_q,
                                                  fm_ns_q, fm_s_q, escal_q, lockup_q};
               exdf_pkg::ADR_ACTIVE: WB_DAT_O <= {25'h0, active_q};
               exdf_pkg::ADR_PEND: WB_DAT_O <= {25'h0, pend_q};
               default: WB_DAT_O <= '0;
            endcase
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_hf_ret_clear: assert property (@(posedge CLK) disable iff (RESET)
      RET_VALID && rawpri == exdf_pkg::PRI_HF_NS && !ACT_VALID && !nstgt
      |=> !active_q[exdf_pkg::B_HF_S]) else $error("hardfault active not cleared");
   chk_nmi_ret_clear: assert property (@(posedge CLK) disable iff (RESET)
      RET_VALID && rawpri == exdf_pkg::PRI_NMI && !ACT_VALID && nstgt
      |=> !active_q[exdf_pkg::B_NMI_NS]) else $error("nmi active not cleared");
   chk_hfs_ret_clear: assert property (@(posedge CLK) disable iff (RESET)
      RET_VALID && rawpri == exdf_pkg::PRI_HF_S && !ACT_VALID
      |=> !active_q[exdf_pkg::B_HF_S]) else $error("secure hardfault not cleared");
   chk_mask_keep: assert property (@(posedge CLK) disable iff (RESET)
      RET_VALID && !wr_st |=> $stable(dismask_q) && $stable(base_priority_mask_q))
      else $error("masks changed on return");
   chk_fm_neg_keep: assert property (@(posedge CLK) disable iff (RESET)
      RET_VALID && rawpri < exdf_pkg::PRI_ZERO && !wr_st |=> $stable(fm_s_q) && $stable(fm_ns_q))
      else $error("fault mask cleared on nmi or hardfault return");
   chk_lock_enter: assert property (@(posedge CLK) disable iff (RESET)
      df_act && DF_TERMINAL && !df_beats_oe |=> LOCKUP && LOCKUP_PRI == $past(OE_PRI))
      else $error("terminal fault did not lock up");
   chk_df_first: assert property (@(posedge CLK) disable iff (RESET)
      df_act && df_beats_oe && !res_pend_mon |=> TAKE_VALID && TAKE_EXC == $past(DF_FAULT))
      else $error("higher priority derived fault not taken");
   chk_lock_hold: assert property (@(posedge CLK) disable iff (RESET)
      LOCKUP && !DBG_LOCKUP_EXIT |=> LOCKUP) else $error("lockup dropped");
   chk_escal_set: assert property (@(posedge CLK) disable iff (RESET)
      esc_set |=> escal_q) else $error("escalation flag not set");
endmodule
`default_nettype wire

// ### exdf_pkg.sv
`default_nettype none
package exdf_pkg;
   // ************************************************************
   // widths and fixed exception numbers
   // ************************************************************
   localparam int EXC_W = 9;
   localparam int PRI_W = 10;
   localparam logic [8:0] EXC_NONE = 9'h000;
   localparam logic [8:0] EXC_NMI = 9'h002;
   localparam logic [8:0] EXC_HARDFAULT = 9'h003;
   localparam logic [8:0] EXC_DBGMON = 9'h00c;
   // signed fixed priorities
   localparam logic signed [9:0] PRI_HF_NS = -10'sd1;
   localparam logic signed [9:0] PRI_NMI = -10'sd2;
   localparam logic signed [9:0] PRI_HF_S = -10'sd3;
   localparam logic signed [9:0] PRI_ZERO = 10'sd0;
   // ************************************************************
   // register map (32-bit words, byte addresses)
   // ************************************************************
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_ACTIVE = 8'h08;
   localparam logic [7:0] ADR_PEND = 8'h0c;
   localparam int CTRL_NSTGT = 0;
   localparam int CTRL_MAINEXT = 1;
   localparam int CTRL_SECEXT = 2;
   localparam int ST_LOCKUP = 0;
   localparam int ST_ESCAL = 1;
   localparam int ST_FM_S = 2;
   localparam int ST_FM_NS = 3;
   localparam int ST_DISMASK = 4;
   localparam int ST_BASE_PRIORITY_MASK = 8;
   // active/pend bit positions: hf_s, hf_ns, nmi_s, nmi_ns, other secure, other nonsecure, dbgmon
   localparam int B_HF_S = 0;
   localparam int B_HF_NS = 1;
   localparam int B_NMI_S = 2;
   localparam int B_NMI_NS = 3;
   localparam int B_OTHER_S = 4;
   localparam int B_OTHER_NS = 5;
   localparam int B_DBGMON = 6;
   localparam int NBITS = 7;
   localparam logic [2:0] CTRL_RST = 3'h6;
endpackage
`default_nettype wire

// ### exdf_pipe_model.sv
`default_nettype none
module exdf_pipe_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       man_req,
   input  wire logic [8:0] man_exc,
   input  wire logic       man_sec,
   input  wire logic       auto_en,
   input  wire logic [3:0] delay,
   input  wire logic       take_valid,
   input  wire logic [8:0] take_exc,
   input  wire logic       take_sec,
   output logic            act_valid,
   output logic      [8:0] act_exc,
   output logic            act_sec
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] wait_q;
   // ************
   // activation
   // ************
   // a taken target is entered delay+2 cycles after it is taken, so slow entries show
   always_ff @(posedge clk) begin
      act_valid <= 1'h0;
      act_exc   <= ~act_exc;
      act_sec   <= ~act_sec;
      if (reset) begin
         wait_q  <= 5'h00;
         act_exc <= 9'h000;
         act_sec <= 1'h0;
      end else if (man_req) begin
         act_valid <= 1'h1;
         act_exc   <= man_exc;
         act_sec   <= man_sec;
      end else if (take_valid && auto_en) begin
         wait_q <= {1'h0, delay} + 5'h01;
      end else if (wait_q != 5'h00) begin
         wait_q <= wait_q - 5'h01;
         if (wait_q == 5'h01) begin
            act_valid <= 1'h1;
            act_exc   <= take_exc;
            act_sec   <= take_sec;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] m1 = 10'h3ff, m2 = 10'h3fe, m3 = 10'h3fd;
   localparam logic [9:0] p0 = 10'h000, p4 = 10'h004, p8 = 10'h008;
   localparam logic [8:0] e16 = 9'h010, e0 = 9'h000;
   logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic        ack, rv = 1'h0, rs = 1'h0, dv = 1'h0, ds = 1'h0, dt = 1'h0;
   logic        dl = 1'h0, os = 1'h0, dbg = 1'h0, mr = 1'h0, ms = 1'h0, ae = 1'h0;
   logic [9:0]  rp = 10'h000, dp = 10'h000, op = 10'h000, pp = 10'h000, lp;
   logic [8:0]  re = 9'h000, dfl = 9'h000, dof = 9'h000, oe = 9'h000, me = 9'h000;
   logic        act_v, act_s, tv, ts, lk;
   logic [8:0]  act_e, te;
   int          err_total = 0, total_checks = 0;
   always #12.5 clk = ~clk;
   exdf_unit exdf_unit_inst (.CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .RET_VALID(rv), .RET_RAWPRI(rp), .RET_EXC(re), .RET_TGT_SEC(rs),
      .DF_VALID(dv), .DF_FAULT(dfl), .DF_ORIG_FAULT(dof), .DF_SEC(ds), .DF_TERMINAL(dt),
      .DF_LOCKUP(dl), .DF_PRI(dp), .OE_EXC(oe), .OE_SEC(os), .OE_PRI(op), .PE_PRI(pp),
      .ACT_VALID(act_v), .ACT_EXC(act_e), .ACT_SEC(act_s), .DBG_LOCKUP_EXIT(dbg),
      .TAKE_VALID(tv), .TAKE_EXC(te), .TAKE_SEC(ts), .LOCKUP(lk), .LOCKUP_PRI(lp));
   exdf_pipe_model exdf_pipe_model_inst (.clk(clk), .reset(rst), .man_req(mr),
      .man_exc(me), .man_sec(ms), .auto_en(ae), .delay(4'h6), .take_valid(tv),
      .take_exc(te), .take_sec(ts), .act_valid(act_v), .act_exc(act_e), .act_sec(act_s));
   // ************
   // helpers
   // ************
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic reset_dut();
      @(posedge clk);
      rst <= 1'h1;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
   endtask
   // ack is read before the edge's own updates land, which is the sampled value
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'h1 && n < 20);
      if (n >= 20) err_total++;
      rdat = dat_o;
      {cyc, stb} <= 2'h0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(n, rdat, e);
   endtask
   task automatic act(input logic [8:0] e, input logic s);
      @(posedge clk);
      {mr, me, ms} <= {1'h1, e, s};
      @(posedge clk);
      mr <= 1'h0;
      @(posedge clk);
   endtask
   task automatic ret(input logic [9:0] p, input logic [8:0] e, input logic s);
      @(posedge clk);
      {rv, rp, re, rs} <= {1'h1, p, e, s};
      @(posedge clk);
      rv <= 1'h0;
   endtask
   task automatic df(input logic [8:0] f, o, input logic s, t, l, input logic [9:0] p,
                     input logic [8:0] x, input logic xs, input logic [9:0] xp, pe);
      @(posedge clk);
      {dv, dfl, dof, ds, dt, dl, dp} <= {1'h1, f, o, s, t, l, p};
      {oe, os, op, pp} <= {x, xs, xp, pe};
      @(posedge clk);
      dv <= 1'h0;
      #1;
   endtask
   // ************
   // scenarios
   // ************
   task automatic t_neg();
      act(9'h003, 1'h1);
      act(9'h002, 1'h1);
      ret(m1, e0, 1'h0);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h4);
      ret(m2, e0, 1'h0);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h0);
      bus(1'h1, exdf_pkg::ADR_CTRL, 32'h7);
      act(9'h003, 1'h0);
      act(9'h003, 1'h1);
      act(9'h002, 1'h0);
      ret(m1, e0, 1'h0);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h9);
      ret(m3, e0, 1'h0);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h8);
      ret(m2, e0, 1'h0);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h0);
      bus(1'h1, exdf_pkg::ADR_CTRL, 32'h6);
      $display("test negative returns done");
   endtask
   task automatic t_mask();
      bus(1'h1, exdf_pkg::ADR_STATUS, 32'ha55d);
      act(e16, 1'h1);
      act(e16, 1'h0);
      ret(m1, e0, 1'h0);
      rchk("status", exdf_pkg::ADR_STATUS, 32'ha55c);
      ret(p0, e16, 1'h1);
      rchk("status", exdf_pkg::ADR_STATUS, 32'ha558);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h20);
      ret(p0, e16, 1'h0);
      rchk("status", exdf_pkg::ADR_STATUS, 32'ha550);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h0);
      $display("test mask returns done");
   endtask
   task automatic t_derived();
      reset_dut();
      df(9'h003, 9'h005, 1'h1, 1'h0, 1'h0, m1, e16, 1'h0, p4, p8);
      chk("take", 32'({tv, te}), 32'h203);
      rchk("pend", exdf_pkg::ADR_PEND, 32'h1);
      rchk("status", exdf_pkg::ADR_STATUS, 32'h2);
      df(9'h005, 9'h005, 1'h0, 1'h0, 1'h0, m1, 9'h003, 1'h1, p4, p8);
      chk("take_valid", 32'(tv), 32'h0);
      df(9'h003, 9'h003, 1'h1, 1'h1, 1'h0, m1, 9'h003, 1'h1, p4, p8);
      chk("take", 32'({tv, te, ts}), 32'h407);
      bus(1'h1, exdf_pkg::ADR_STATUS, 32'h2);
      rchk("status", exdf_pkg::ADR_STATUS, 32'h0);
      reset_dut();
      ae <= 1'h1;
      df(9'h005, 9'h005, 1'h0, 1'h0, 1'h0, p8, e16, 1'h1, p4, p8);
      chk("take", 32'({tv, te, ts}), 32'h421);
      rchk("pend", exdf_pkg::ADR_PEND, 32'h20);
      repeat (8) @(posedge clk);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h10);
      ae <= 1'h0;
      reset_dut();
      df(9'h00c, 9'h00c, 1'h1, 1'h0, 1'h0, p8, e16, 1'h0, p4, p4);
      chk("take", 32'({tv, te, ts}), 32'h420);
      rchk("pend", exdf_pkg::ADR_PEND, 32'h40);
      $display("test derived faults done");
   endtask
   task automatic t_lock();
      reset_dut();
      df(9'h005, 9'h005, 1'h0, 1'h0, 1'h1, p8, e16, 1'h1, p4, p8);
      chk("lockup", 32'({tv, lk, lp}), 32'h404);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h10);
      rchk("pend", exdf_pkg::ADR_PEND, 32'h0);
      df(9'h003, 9'h005, 1'h1, 1'h0, 1'h0, m1, e16, 1'h0, p4, p8);
      chk("ignored", 32'({tv, lk}), 32'h1);
      rchk("status", exdf_pkg::ADR_STATUS, 32'h1);
      @(posedge clk);
      dbg <= 1'h1;
      @(posedge clk);
      dbg <= 1'h0;
      #1;
      chk("lockup", 32'(lk), 32'h0);
      reset_dut();
      df(9'h003, 9'h003, 1'h1, 1'h1, 1'h0, p8, e16, 1'h0, p4, p8);
      chk("lockup", 32'({tv, lk, lp}), 32'h404);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h20);
      $display("test lockup done");
   endtask
   // no extensions, then main extension without security extension
   task automatic t_noext();
      reset_dut();
      bus(1'h1, exdf_pkg::ADR_CTRL, 32'h0);
      bus(1'h1, exdf_pkg::ADR_STATUS, 32'hc);
      act(e16, 1'h1);
      ret(p0, e16, 1'h1);
      df(9'h003, 9'h005, 1'h0, 1'h0, 1'h0, m1, e16, 1'h0, p4, p8);
      chk("take", 32'({tv, te}), 32'h203);
      rchk("status", exdf_pkg::ADR_STATUS, 32'hc);
      rchk("active", exdf_pkg::ADR_ACTIVE, 32'h10);
      bus(1'h1, exdf_pkg::ADR_CTRL, 32'h2);
      ret(p0, e16, 1'h1);
      rchk("status", exdf_pkg::ADR_STATUS, 32'h4);
      $display("test no extension done");
   endtask
   initial begin
      reset_dut();
      rchk("ctrl", exdf_pkg::ADR_CTRL, 32'h6);
      bus(1'h1, 8'h10, 32'hffff);
      rchk("unmapped", 8'h10, 32'h0);
      t_neg();
      t_mask();
      t_derived();
      t_lock();
      t_noext();
      end_sim();
   end
   initial begin
      #(25 * 5000);
      err_total++;
      end_sim();
   end
endmodule
`default_nettype wire
